// ### rtl/sdai_area_ctrl.sv
// sdram controller for chip-select area three on a 32-bit data bus
`timescale 1ns/1ns

// What this block does
// - handles parts with 11 to 13 row bits, 8 to 10 column bits, four banks
// - pin feeding memory A10 selects precharge mode in read and write commands
// - burst length is one; wide writes become back-to-back column commands, wide reads repeat read, wait and data
// - single-write and burst-write mode settings behave identically here
// - row phase drives address 23..11, column phase 14..2, on pins 14..2
// - column phase precharge pin carries a fixed level, not an address bit
// - a 16-bit write to the mode page triggers the mode register write
// - mode setup drives the low access address bits, e.g. 0x880 or 0x0C0
// - mode write starts with precharge-all then precharge-wait idle cycles
// - eight auto-refreshes follow, each trailed by refresh-recovery idle cycles
// - sequence ends with a mode-set command, address pins carry the value
// - reads start with row activate then activate-to-command wait cycles
// - read column command always requests auto precharge
// - cas latency minus one wait cycles sit between read and data
// - data captured in data cycle; bursts repeat read with auto precharge
// - one idle cycle always follows the last read data cycle
// - precharge-wait cycles follow read data before the access ends
// - memory lives in area three; address bit 29 only picks cached view
// - writes use auto precharge, then write-recovery and precharge waits
// - refresh-recovery code 10 gives five idle cycles
module sdai_area_ctrl #(
  parameter int DIV     = sdai_pkg::MEM_DIV,
  parameter int WORDS_W = 3
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [1:0]         prechargeWait,
  input  wire logic [1:0]         actToCmdWait,
  input  wire logic [1:0]         casLatency,
  input  wire logic [1:0]         writeRecovery,
  input  wire logic [1:0]         refreshRecovery,
  input  wire logic               reqValid,
  input  wire logic               reqWrite,
  input  wire logic               reqHalf,
  input  wire logic [31:0]        reqAddr,
  input  wire logic [WORDS_W-1:0] reqWords,
  input  wire logic [31:0]        reqWData,
  output logic                    reqReady,
  output logic                    wrTake,
  output logic                    rdValid,
  output logic [31:0]             rdData,
  output logic                    busy,
  output logic                    memClk,
  output logic                    memCke,
  output logic                    memCsN,
  output logic                    memRasN,
  output logic                    memCasN,
  output logic                    memWeN,
  output logic [16:0]             memAddr,
  output logic [3:0]              memDqm,
  output logic [31:0]             memDqOut,
  output logic                    memDqOe,
  input  wire logic [31:0]        memDqIn
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRECHARGE_ALL_CMD, S_REF, S_MRS, S_ACT, S_RD, S_DATA, S_TDE, S_WR, S_WAIT
  } sdai_state_t;

  sdai_state_t        state;
  sdai_state_t        retState;
  logic [3:0]         waitCnt;
  logic [3:0]         refLeft;
  logic [WORDS_W-1:0] wordsLeft;
  logic [23:0]        curAddr;
  logic               isWrite;
  logic [11:0]        modeLow;
  logic [3:0]         cmd;
  logic [31:0]        dqMeta;
  logic [31:0]        dqSync;
  logic               firstPhase;
  logic               tick;
  logic [3:0]         tRp;
  logic [3:0]         tRcd;
  logic [3:0]         casWait;
  logic [3:0]         write_recovery_field;
  logic [3:0]         tRc;
  logic               modeHit;
  logic               areaHit;

  sdai_tick_gen #(.DIV(DIV)) u_tick (
    .clock      (clock),
    .reset      (reset),
    .firstPhase (firstPhase),
    .tick       (tick),
    .memClk     (memClk)
  );

  function automatic logic [3:0] recoveryCycles(input logic [1:0] code);
    case (code)
      2'h0:    recoveryCycles = 4'h2;
      2'h1:    recoveryCycles = 4'h3;
      2'h2:    recoveryCycles = 4'h5;
      default: recoveryCycles = 4'h8;
    endcase
  endfunction

  // zero cycles skips the wait state altogether
  function automatic sdai_state_t pick(input logic [3:0] n, input sdai_state_t nxt);
    pick = (n == 4'h0) ? nxt : S_WAIT;
  endfunction

  // thirteen row pins and two bank pins cover every supported geometry
  function automatic logic [16:0] rowPins(input logic [23:0] a);
    rowPins = {a[23:22], a[21:9], 2'b00};
  endfunction

  function automatic logic [16:0] colPins(input logic [23:0] a);
    colPins = {a[23:22], a[12:11], 1'b1, a[9:0], 2'b00};
  endfunction

  assign tRp     = {2'b00, prechargeWait};
  assign tRcd    = {2'b00, actToCmdWait};
  assign casWait = {2'b00, casLatency};
  assign write_recovery_field    = {2'b00, writeRecovery};
  assign tRc     = recoveryCycles(refreshRecovery);

  // both mode-write variants decode the same way; only the area decode ignores bit 29
  assign modeHit = reqWrite && reqHalf
                   && (reqAddr[31:12] == sdai_pkg::MODE_PAGE);
  assign areaHit = (reqAddr[28:26] == sdai_pkg::AREA3_SEL);

  assign reqReady = tick && (state == S_IDLE);
  assign wrTake   = firstPhase && (state == S_WR);
  assign busy     = (state != S_IDLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      state     <= S_IDLE;
      retState  <= S_IDLE;
      waitCnt   <= 4'h0;
      refLeft   <= 4'h0;
      wordsLeft <= '0;
      curAddr   <= 24'h000000;
      isWrite   <= 1'b0;
      modeLow   <= 12'h000;
    end else if (tick) begin
      case (state)
        S_IDLE: begin
          if (reqValid) begin
            curAddr   <= reqAddr[25:2];
            isWrite   <= reqWrite;
            modeLow   <= reqAddr[11:0];
            wordsLeft <= (reqWords == '0) ? WORDS_W'(1) : reqWords;
            if (modeHit) begin
              state <= S_PRECHARGE_ALL_CMD;
            end else if (areaHit) begin
              state <= S_ACT;
            end
          end
        end
        S_PRECHARGE_ALL_CMD: begin
          refLeft  <= sdai_pkg::REF_COUNT;
          state    <= pick(tRp, S_REF);
          retState <= S_REF;
          waitCnt  <= tRp - 4'h1;
        end
        S_REF: begin
          refLeft  <= refLeft - 4'h1;
          state    <= pick(tRc, (refLeft == 4'h1) ? S_MRS : S_REF);
          retState <= (refLeft == 4'h1) ? S_MRS : S_REF;
          waitCnt  <= tRc - 4'h1;
        end
        S_MRS: begin
          // recovery also guards the next activate after the mode set
          state    <= pick(tRc, S_IDLE);
          retState <= S_IDLE;
          waitCnt  <= tRc - 4'h1;
        end
        S_ACT: begin
          state    <= pick(tRcd, isWrite ? S_WR : S_RD);
          retState <= isWrite ? S_WR : S_RD;
          waitCnt  <= tRcd - 4'h1;
        end
        S_RD: begin
          state    <= pick(casWait, S_DATA);
          retState <= S_DATA;
          waitCnt  <= casWait - 4'h1;
        end
        S_DATA: begin
          if (wordsLeft > WORDS_W'(1)) begin
            wordsLeft <= wordsLeft - WORDS_W'(1);
            curAddr   <= curAddr + 24'h000001;
            state     <= S_RD;
          end else begin
            state <= S_TDE;
          end
        end
        S_TDE: begin
          state    <= pick(tRp, S_IDLE);
          retState <= S_IDLE;
          waitCnt  <= tRp - 4'h1;
        end
        S_WR: begin
          if (wordsLeft > WORDS_W'(1)) begin
            wordsLeft <= wordsLeft - WORDS_W'(1);
            curAddr   <= curAddr + 24'h000001;
          end else begin
            state    <= pick(write_recovery_field + tRp, S_IDLE);
            retState <= S_IDLE;
            waitCnt  <= write_recovery_field + tRp - 4'h1;
          end
        end
        S_WAIT: begin
          if (waitCnt == 4'h0) begin
            state <= retState;
          end else begin
            waitCnt <= waitCnt - 4'h1;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // pins load in the first phase so they settle before the memory clock rises
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd     <= sdai_pkg::CMD_DESEL;
      memAddr <= sdai_pkg::ADDR_RESET;
      memDqm  <= sdai_pkg::DQM_IDLE;
    end else if (firstPhase) begin
      memDqm <= busy ? sdai_pkg::DQM_ACTIVE : sdai_pkg::DQM_IDLE;
      case (state)
        S_PRECHARGE_ALL_CMD: begin
          cmd     <= sdai_pkg::CMD_PRECHARGE_ALL_CMD;
          memAddr <= 17'(1) << sdai_pkg::AP_PIN;
        end
        S_REF: begin
          cmd     <= sdai_pkg::CMD_REF;
          memAddr <= sdai_pkg::ADDR_RESET;
        end
        S_MRS: begin
          cmd     <= sdai_pkg::CMD_MODE;
          memAddr <= {5'h00, modeLow};
        end
        S_ACT: begin
          cmd     <= sdai_pkg::CMD_ACT;
          memAddr <= rowPins(curAddr);
        end
        S_RD: begin
          cmd     <= sdai_pkg::CMD_READ;
          memAddr <= colPins(curAddr);
        end
        S_WR: begin
          cmd     <= sdai_pkg::CMD_WRITE;
          memAddr <= colPins(curAddr);
        end
        default: begin
          cmd     <= busy ? sdai_pkg::CMD_NOP : sdai_pkg::CMD_DESEL;
          memAddr <= sdai_pkg::ADDR_RESET;
        end
      endcase
    end
  end

  assign memCsN  = cmd[3];
  assign memRasN = cmd[2];
  assign memCasN = cmd[1];
  assign memWeN  = cmd[0];

  always_ff @(posedge clock) begin
    if (reset) begin
      memCke <= 1'b0;
    end else begin
      memCke <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      memDqOut <= 32'h00000000;
      memDqOe  <= 1'b0;
    end else if (firstPhase) begin
      memDqOe <= (state == S_WR);
      if (state == S_WR) begin
        memDqOut <= reqWData;
      end
    end
  end

  // read data crosses from the pins through two flops before capture
  always_ff @(posedge clock) begin
    if (reset) begin
      dqMeta <= 32'h00000000;
      dqSync <= 32'h00000000;
    end else begin
      dqMeta <= memDqIn;
      dqSync <= dqMeta;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdValid <= 1'b0;
      rdData  <= 32'h00000000;
    end else begin
      rdValid <= tick && (state == S_DATA);
      if (tick && (state == S_DATA)) begin
        rdData <= dqSync;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_mode_value: assert property (
    (cmd == sdai_pkg::CMD_MODE) |-> (memAddr == {5'h00, modeLow}))
    else $error("mode set address differs from access address");
  a_precharge_all_cmd_then_ref: assert property (
    (tick && state == S_PRECHARGE_ALL_CMD) |=> (retState == S_REF) && (refLeft == sdai_pkg::REF_COUNT))
    else $error("precharge all not followed by refresh");
  a_eight_refresh: assert property (
    (tick && state == S_MRS) |-> (refLeft == 4'h0))
    else $error("mode set before eight refreshes");
  a_read_autopre: assert property (
    (cmd == sdai_pkg::CMD_READ) |-> memAddr[sdai_pkg::AP_PIN])
    else $error("read without auto precharge");
  a_write_autopre: assert property (
    (cmd == sdai_pkg::CMD_WRITE) |-> memAddr[sdai_pkg::AP_PIN] && memDqOe)
    else $error("write without auto precharge or data drive");
  a_row_bank_map: assert property (
    ($past(firstPhase) && cmd == sdai_pkg::CMD_ACT)
      |-> (memAddr[14:2] == curAddr[21:9]) && (memAddr[16:15] == curAddr[23:22]))
    else $error("row phase address mapping wrong");
  a_tde_after_last: assert property (
    (tick && state == S_DATA && wordsLeft == WORDS_W'(1)) |=> (state == S_TDE))
    else $error("idle cycle after read data missing");
  a_cas_wait_one: assert property (
    (tick && state == S_RD && casLatency == 2'h1)
      |=> (state == S_WAIT) && (waitCnt == 4'h0) && (retState == S_DATA))
    else $error("cas wait count wrong");
  a_act_first: assert property (
    (reqReady && reqValid && !modeHit && areaHit) |=> (state == S_ACT))
    else $error("access did not start with activate");
  a_rd_pulse: assert property (
    rdValid |-> $past(tick) && ($past(state) == S_DATA))
    else $error("read data valid outside data cycle");

  c_mode_seq:   cover property (tick && state == S_MRS);
  c_burst_read: cover property (tick && state == S_DATA && wordsLeft > WORDS_W'(1));
  c_burst_wr:   cover property (tick && state == S_WR && wordsLeft > WORDS_W'(1));
endmodule

// ### rtl/sdai_tick_gen.sv
// shared constants of the sdram area interface and its memory clock divider
`timescale 1ns/1ns

package sdai_pkg;
  // command pins in the order chip select, row strobe, column strobe, write enable
  localparam logic [3:0]  CMD_DESEL   = 4'hF;
  localparam logic [3:0]  CMD_NOP     = 4'h7;
  localparam logic [3:0]  CMD_ACT     = 4'h3;
  localparam logic [3:0]  CMD_READ    = 4'h5;
  localparam logic [3:0]  CMD_WRITE   = 4'h4;
  localparam logic [3:0]  CMD_PRECHARGE_ALL_CMD    = 4'h2;
  localparam logic [3:0]  CMD_REF     = 4'h1;
  localparam logic [3:0]  CMD_MODE    = 4'h0;
  localparam logic [19:0] MODE_PAGE   = 20'hFFFC5;
  localparam logic [2:0]  AREA3_SEL   = 3'h3;
  localparam int          AP_PIN      = 12;
  localparam logic [3:0]  REF_COUNT   = 4'h8;
  localparam int          MEM_DIV     = 4;
  localparam logic [16:0] ADDR_RESET  = 17'h00000;
  localparam logic [3:0]  DQM_ACTIVE  = 4'h0;
  localparam logic [3:0]  DQM_IDLE    = 4'hF;
endpackage

module sdai_tick_gen #(
  parameter int DIV = sdai_pkg::MEM_DIV
) (
  input  wire logic clock,
  input  wire logic reset,
  output logic      firstPhase,
  output logic      tick,
  output logic      memClk
);
  logic [7:0] phase;
  logic [7:0] next_phase;

  assign next_phase = (phase == 8'(DIV - 1)) ? 8'h00 : phase + 8'h01;
  assign firstPhase = (phase == 8'h00);
  assign tick       = (phase == 8'(DIV - 1));

  always_ff @(posedge clock) begin
    if (reset) begin
      phase <= 8'h00;
    end else begin
      phase <= next_phase;
    end
  end

  // memory clock rises mid period so pins loaded in phase zero have settled
  always_ff @(posedge clock) begin
    if (reset) begin
      memClk <= 1'b0;
    end else begin
      memClk <= (next_phase >= 8'(DIV / 2));
    end
  end
endmodule

// ### sim/sdai_mem_model.sv
// behavioural sdram model on the far side of the area interface
`timescale 1ns/1ns

module sdai_mem_model (
  input  wire logic        memClk,
  input  wire logic        memCsN,
  input  wire logic        memRasN,
  input  wire logic        memCasN,
  input  wire logic        memWeN,
  input  wire logic [16:0] memAddr,
  input  wire logic [31:0] memDqOut,
  input  wire logic        memDqOe,
  output logic      [31:0] memDqIn,
  output int               cnt [8],
  output int               gapMin,
  output int               gapMax,
  output int               pallGap,
  output int               actGap,
  output int               errCnt,
  output logic      [16:0] modeAddr
);
  logic [31:0] store [logic [31:0]];
  logic [12:0] rowOf [4];
  logic [3:0]  open;
  logic [3:0]  apd;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [31:0] key;
  logic [31:0] due;
  int          cl, dueCnt, rise, g, lastRef, lastAct, lastPall;

  assign cmd  = {memCsN, memRasN, memCasN, memWeN};
  assign bank = memAddr[16:15];
  // pin 12 is the precharge select in column phase, so it is no part of the word
  assign key  = {4'h0, bank, rowOf[bank], memAddr[14:13], 1'b0, memAddr[11:2]};

  initial begin
    cnt = '{default: 0};
    open = 4'h0;
    apd = 4'h0;
    cl = 2;
    dueCnt = 0;
    rise = 0;
    lastRef = 0;
    lastAct = 0;
    lastPall = 0;
    errCnt = 0;
    memDqIn = 32'h0;
  end

  always @(posedge memClk) begin
    rise++;
    g = 0;
    if (dueCnt > 0) dueCnt--;
    if (!cmd[3]) cnt[cmd[2:0]]++;
    case (cmd)
      sdai_pkg::CMD_ACT: begin
        if (open[bank] && !apd[bank]) errCnt++;
        open[bank] = 1'b1;
        apd[bank] = 1'b0;
        rowOf[bank] = memAddr[14:2];
        lastAct = rise;
      end
      sdai_pkg::CMD_READ, sdai_pkg::CMD_WRITE: begin
        if (!open[bank] || !memAddr[sdai_pkg::AP_PIN]) errCnt++;
        if (!apd[bank]) actGap = rise - lastAct;
        apd[bank] = 1'b1;
        if (cmd == sdai_pkg::CMD_WRITE) begin
          if (!memDqOe) errCnt++;
          store[key] = memDqOut;
        end else begin
          due = store.exists(key) ? store[key] : {4'hC, key[27:0]};
          // the word appears at the cl-th rise after the command, as a real part does
          dueCnt = cl + 1;
        end
      end
      sdai_pkg::CMD_PRECHARGE_ALL_CMD: begin
        open = 4'h0;
        lastPall = rise;
        lastRef = 0;
        gapMin = 999;
        gapMax = 0;
      end
      sdai_pkg::CMD_REF: begin
        if (lastRef == 0) pallGap = rise - lastPall;
        else g = rise - lastRef;
        lastRef = rise;
      end
      sdai_pkg::CMD_MODE: begin
        modeAddr = memAddr;
        cl = int'(memAddr[8:6]);
        g = rise - lastRef;
      end
      default: ;
    endcase
    if (g > 0 && g < gapMin) gapMin = g;
    if (g > gapMax) gapMax = g;
    // a released bus flips every period so a late capture cannot pass by luck
    memDqIn <= #1 (dueCnt == 1) ? due : ~memDqIn;
  end
endmodule

// ### sim/tb.sv
// self-checking bench for the sdram area interface with its memory model
`timescale 1ns/1ns

module tb;
  localparam int DIV = 8;
  typedef struct {
    logic [1:0]  kind;
    logic [31:0] addr;
    logic [2:0]  words;
    logic [1:0]  cas;
    logic [31:0] exp;
  } sdai_row_t;
  sdai_row_t rows [8] = '{
    '{2'h0, 32'hFFFC5880, 3'h1, 2'h1, 32'h00000880},
    '{2'h0, 32'hFFFC5080, 3'h1, 2'h1, 32'h00000080},
    '{2'h0, 32'hFFFC50C0, 3'h1, 2'h2, 32'h000000C0},
    '{2'h0, 32'hFFFC58C0, 3'h1, 2'h2, 32'h000008C0},
    '{2'h1, 32'h0D123458, 3'h3, 2'h2, 32'h11110000},
    '{2'h2, 32'h0D123458, 3'h3, 2'h2, 32'h11110000},
    '{2'h1, 32'h2E000FFC, 3'h1, 2'h2, 32'hA5A55A5A},
    '{2'h2, 32'h0E000FFC, 3'h1, 2'h2, 32'hA5A55A5A}};
  logic        clock, reset, reqValid, reqWrite, reqHalf, reqReady, wrTake, rdValid, busy;
  logic [1:0]  prechargeWait, actToCmdWait, casLatency, writeRecovery, refreshRecovery;
  logic [2:0]  reqWords;
  logic [31:0] reqAddr, reqWData, rdData, memDqOut, memDqIn;
  logic        memClk, memCke, memCsN, memRasN, memCasN, memWeN, memDqOe;
  logic [16:0] memAddr, modeAddr, actA, colA;
  logic [3:0]  memDqm, cmd;
  logic [31:0] rdQ [$];
  int          cnt [8];
  int          c0 [8];
  int          gapMin, gapMax, pallGap, actGap, errCnt;
  int          cyc, takeCyc, rdCyc0, rdCyc, busyEnd, nTake, g1, failCount, checked;

  assign cmd = {memCsN, memRasN, memCasN, memWeN};
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  sdai_area_ctrl #(.DIV(DIV), .WORDS_W(3)) dut_u (.clock(clock), .reset(reset),
    .prechargeWait(prechargeWait), .actToCmdWait(actToCmdWait), .casLatency(casLatency),
    .writeRecovery(writeRecovery), .refreshRecovery(refreshRecovery), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqHalf(reqHalf), .reqAddr(reqAddr), .reqWords(reqWords),
    .reqWData(reqWData), .reqReady(reqReady), .wrTake(wrTake), .rdValid(rdValid),
    .rdData(rdData), .busy(busy), .memClk(memClk), .memCke(memCke), .memCsN(memCsN),
    .memRasN(memRasN), .memCasN(memCasN), .memWeN(memWeN), .memAddr(memAddr),
    .memDqm(memDqm), .memDqOut(memDqOut), .memDqOe(memDqOe), .memDqIn(memDqIn));

  sdai_mem_model mdl_u (.memClk(memClk), .memCsN(memCsN), .memRasN(memRasN),
    .memCasN(memCasN), .memWeN(memWeN), .memAddr(memAddr), .memDqOut(memDqOut),
    .memDqOe(memDqOe), .memDqIn(memDqIn), .cnt(cnt), .gapMin(gapMin), .gapMax(gapMax),
    .pallGap(pallGap), .actGap(actGap), .errCnt(errCnt), .modeAddr(modeAddr));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // entered at a falling edge; returns at the first falling edge with busy low
  task automatic run(input logic w, input logic h, input logic [31:0] a,
                     input logic [2:0] n, input logic [31:0] d);
    int i;
    logic tp;
    tp = 1'b0;
    nTake = 0;
    rdQ.delete();
    colA = 17'h0;
    reqWrite = w;
    reqHalf = h;
    reqAddr = a;
    reqWords = n;
    reqWData = d;
    reqValid = 1'b1;
    for (i = 0; i < 100 && reqReady !== 1'b1; i++) @(negedge clock);
    if (i >= 100) begin
      failCount++;
      $display("CHECK FAILED reqReady expected 1 seen stuck low");
      test_done();
    end
    @(negedge clock);
    takeCyc = cyc;
    reqValid = 1'b0;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
      if (rdValid === 1'b1) begin
        if (rdQ.size() == 0) rdCyc0 = cyc;
        rdQ.push_back(rdData);
        rdCyc = cyc;
      end
      if (tp) reqWData = reqWData + 32'h1;
      tp = (wrTake === 1'b1);
      if (tp) nTake++;
      if (cmd == sdai_pkg::CMD_ACT) actA = memAddr;
      if ((cmd == sdai_pkg::CMD_READ || cmd == sdai_pkg::CMD_WRITE) && colA == 17'h0)
        colA = memAddr;
      @(negedge clock);
    end
    busyEnd = cyc;
    if (i >= 3000) begin
      failCount++;
      $display("CHECK FAILED busy expected low seen stuck");
      test_done();
    end
  endtask

  initial begin
    int r;
    int i;
    clock = 1'b0;
    reset = 1'b1;
    cyc = 0;
    failCount = 0;
    checked = 0;
    prechargeWait = 2'h1;
    actToCmdWait = 2'h2;
    casLatency = 2'h1;
    writeRecovery = 2'h2;
    refreshRecovery = 2'h2;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqHalf = 1'b0;
    reqAddr = 32'h0;
    reqWords = 3'h1;
    reqWData = 32'h0;
    repeat (6) @(negedge clock);
    check("cke", 32'(memCke), 32'h0);
    check("cmd", 32'(cmd), 32'(sdai_pkg::CMD_DESEL));
    check("dqm", 32'(memDqm), 32'hF);
    check("oe", 32'(memDqOe), 32'h0);
    reset = 1'b0;
    for (r = 0; r < 8; r++) begin
      casLatency = rows[r].cas;
      c0 = cnt;
      run(rows[r].kind != 2'h2, rows[r].kind == 2'h0, rows[r].addr, rows[r].words, rows[r].exp);
      if (rows[r].kind == 2'h0) begin
        check("mode pins", 32'(modeAddr), {20'h0, rows[r].exp[11:0]});
        check("precharge_all_cmd", 32'(cnt[2] - c0[2]), 32'h1);
        check("refs", 32'(cnt[1] - c0[1]), 32'h8);
        check("mrs", 32'(cnt[0] - c0[0]), 32'h1);
        check("precharge_all_cmd gap", 32'(pallGap), 32'h2);
        check("ref gap min", 32'(gapMin), 32'h6);
        check("ref gap max", 32'(gapMax), 32'h6);
      end else begin
        check("acts", 32'(cnt[3] - c0[3]), 32'h1);
        check("act gap", 32'(actGap), 32'h3);
        check("row pins", 32'(actA), {15'h0, rows[r].addr[25:11], 2'h0});
        check("col pins", 32'(colA), {15'h0, rows[r].addr[25:24], rows[r].addr[14:13], 1'b1,
              rows[r].addr[11:2], 2'h0});
        if (rows[r].kind == 2'h1) begin
          check("wr cmds", 32'(cnt[4] - c0[4]), 32'(rows[r].words));
          check("takes", 32'(nTake), 32'(rows[r].words));
        end else begin
          check("rd cmds", 32'(cnt[5] - c0[5]), 32'(rows[r].words));
          check("words", 32'(rdQ.size()), 32'(rows[r].words));
          for (i = 0; i < rows[r].words; i++) check("data", rdQ[i], rows[r].exp + 32'(i));
          check("latency", 32'(rdCyc0 - takeCyc), 32'(DIV * 7));
        end
      end
    end
    casLatency = 2'h1;
    run(1'b1, 1'b1, 32'hFFFC5080, 3'h1, 32'h0);
    run(1'b0, 1'b0, 32'h0D123458, 3'h1, 32'h0);
    check("cl2 latency", 32'(rdCyc0 - takeCyc), 32'(DIV * 6));
    check("cl2 data", rdQ[0], 32'h11110000);
    g1 = busyEnd - rdCyc;
    prechargeWait = 2'h2;
    run(1'b0, 1'b0, 32'h0E000FFC, 3'h1, 32'h0);
    check("trp step", 32'(busyEnd - rdCyc - g1), 32'(DIV));
    check("tde", 32'(g1 >= 2 * DIV - 2), 32'h1);
    c0 = cnt;
    run(1'b0, 1'b0, 32'h10000000, 3'h1, 32'h0);
    check("unmapped busy", 32'(busyEnd - takeCyc), 32'h0);
    check("unmapped act", 32'(cnt[3] - c0[3]), 32'h0);
    check("proto errs", 32'(errCnt), 32'h0);
    // reset right after a take must drop the access before any command leaves
    reqWrite = 1'b0;
    reqHalf = 1'b0;
    reqAddr = 32'h0D123458;
    reqWords = 3'h1;
    reqValid = 1'b1;
    for (i = 0; i < 100 && busy !== 1'b1; i++) @(negedge clock);
    check("reset take", 32'(busy), 32'h1);
    reqValid = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    check("reset busy", 32'(busy), 32'h0);
    check("reset cmd", 32'(cmd), 32'(sdai_pkg::CMD_DESEL));
    reset = 1'b0;
    c0 = cnt;
    run(1'b0, 1'b0, 32'h0D123458, 3'h1, 32'h0);
    check("reset act", 32'(cnt[3] - c0[3]), 32'h1);
    check("reset data", rdQ[0], 32'h11110000);
    test_done();
  end
endmodule
